// >>> verilog/als_regs.svh
// Constants shared by both ends of the ambient light link.
`ifndef ALS_REGS_SVH
`define ALS_REGS_SVH
// ****************************************
// Link and command codes
// ****************************************
`define ALS_DEV_ADDR 7'h29
`define ALS_CMD_ACTIVATE 8'h04
`define ALS_CMD_START 8'h08
`define ALS_CMD_STOP 8'h30
`define ALS_CMD_RESERVED 8'h34
`define ALS_SHUTDOWN_BIT 7
// ****************************************
// Reset values and result layout
// ****************************************
`define ALS_CTRL_RST 8'h80
`define ALS_RESULT_RST 16'h0000
`define ALS_VALID_BIT 15
`define ALS_COUNT_MAX 15'h7FFF
// ****************************************
// Timing
// ****************************************
`define ALS_CLK_PERIOD_NS 10
`define ALS_SCL_PERIOD_NS 5000
`define ALS_QTR_CYCLES (`ALS_SCL_PERIOD_NS / (4 * `ALS_CLK_PERIOD_NS))
// ****************************************
// Controller registers on AXI4-Lite
// ****************************************
`define ALS_REG_CMD 4'h0
`define ALS_REG_STATUS 4'h4
`define ALS_REG_RXDATA 4'h8
`define ALS_OP_SEND 2'h0
`define ALS_OP_RECV_BYTE 2'h1
`define ALS_OP_RECV_WORD 2'h2
`define ALS_ST_BUSY 0
`define ALS_ST_NACK 1
`define ALS_RESP_OKAY 2'h0
`define ALS_RESP_SLVERR 2'h2
`endif

// >>> verilog/als_pkg.sv
// Types shared by both ends of the ambient light link.
package als_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ACHK, S_AACK, S_WDATA, S_WCHK, S_WACK, S_RDATA, S_RACK, S_RNEXT
    } als_slv_state_t;
    typedef enum logic [1:0] {
        M_IDLE, M_START, M_BIT, M_STOP
    } als_mst_state_t;
endpackage

// >>> verilog/als_link_if.sv
// Two-wire link between the controller and the sensor.
`timescale 1ns/1ps
interface als_link_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    wire scl;
    wire sda;
    // Pull-ups make each line high unless an enabled driver pulls it low.
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);
    modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
                  output host_sda_oe, input scl, input sda);
    modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface

// >>> verilog/als_sync3.sv
// Three-stage synchroniser with an agreement filter.
`timescale 1ns/1ps
module als_sync3 #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Asynchronous level in, filtered level out
    input wire logic d_i,
    output logic q_o
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q_o <= s3;
            end
        end
    end
endmodule

// >>> verilog/als_dev_end.sv
// Sensor end: two-wire slave, command byte and light count integration.
//
// Function
// R01: Eight-bit command byte, writable and readable.
// R02: Two-byte result, read only from the bus.
// R03: Answer only to address 0x29.
// R04: Send Byte, Receive Byte, Receive Word only; further ACKed reads repeat the second byte.
// R05: Send Byte loads the command byte.
// R06: Write address, direction low, slave acknowledges.
// R07: Data byte MSB first, acknowledged, then stop.
// R08: Byte read: ack address, shift MSB first.
// R09: Word read ends on NACK and stop.
// R10: Count frequency pulses in fifteen bits.
// R11: Result: count in D0-D14, valid in D15.
// R12: Top bit set means shut-down; reset default.
// R13: Shut-down keeps whole byte for readback.
// R14: Command 0x04 activates one-time integration.
// R15: Command 0x08 clears result, starts integrating.
// R16: Command 0x30 stops, sets valid flag.
// R17: Command 0x34 reserved, no function.
// R18: Master sends activate, then start integration.
// R19: Valid flag zero until stop received.
// R20: Result held until next full integration.
// R21: Word read returns lower byte first.
// R22: Other codes stored, state unchanged.
`timescale 1ns/1ps
`include "als_regs.svh"
module als_dev_end
    import als_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Two-wire link
    als_link_if.dev link,
    // Light-derived frequency
    input wire logic freq_i,
    // Sensor state
    output logic [7:0] ctrl_byte_o,
    output logic [15:0] result_o,
    output logic active_o,
    output logic integrating_o
);
    als_slv_state_t state;
    logic scl_q;
    logic sda_q;
    logic freq_q;
    logic scl_d;
    logic sda_d;
    logic freq_d;
    logic [2:0] cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [15:0] snap;
    logic rd_dir;
    logic sda_oe;
    logic [7:0] sensor_control_byte;
    logic [15:0] light_count_result;
    logic active;
    logic integrating;

    // ****************************************
    // Pin sampling and bus events
    // ****************************************
    als_sync3 #(.RST_VAL(1'b1)) u_scl (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .d_i(link.scl), .q_o(scl_q));
    als_sync3 #(.RST_VAL(1'b1)) u_sda (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .d_i(link.sda), .q_o(sda_q));
    als_sync3 #(.RST_VAL(1'b0)) u_freq (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .d_i(freq_i), .q_o(freq_q));

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            freq_d <= 1'b0;
        end else begin
            scl_d <= scl_q;
            sda_d <= sda_q;
            freq_d <= freq_q;
        end
    end

    wire scl_rise = scl_q & ~scl_d;
    wire scl_fall = ~scl_q & scl_d;
    wire start_det = scl_q & scl_d & sda_d & ~sda_q;
    wire stop_det = scl_q & scl_d & ~sda_d & sda_q;
    wire freq_rise = freq_q & ~freq_d;
    // R03 fixed address match
    wire addr_hit = (shreg[7:1] == `ALS_DEV_ADDR);
    wire cmd_take = (state == S_WCHK) & scl_fall & ~start_det & ~stop_det;
    wire [7:0] cmd = shreg;
    wire cmd_shutdown = cmd[`ALS_SHUTDOWN_BIT];
    wire count_full = (light_count_result[14:0] == `ALS_COUNT_MAX);

    // Shut-down reads the command byte; an active sensor reads the result word.
    // R02 R21 lower byte first
    function automatic logic [7:0] tx_byte(input logic idx, input logic act,
                                           input logic [7:0] ctl, input logic [15:0] res);
        if (!act) begin
            tx_byte = ctl;
        end else if (idx) begin
            tx_byte = res[15:8];
        end else begin
            tx_byte = res[7:0];
        end
    endfunction

    wire [7:0] first_byte = tx_byte(1'b0, active, sensor_control_byte, light_count_result);
    wire [7:0] second_byte = tx_byte(1'b1, active, sensor_control_byte, snap);

    // ****************************************
    // Slave protocol engine
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            cnt <= 3'h0;
            shreg <= 8'h00;
            tx <= 8'h00;
            snap <= `ALS_RESULT_RST;
            rd_dir <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_det) begin
            // R07 stop ends any transfer
            state <= S_IDLE;
            sda_oe <= 1'b0;
        end else if (start_det) begin
            state <= S_ADDR;
            cnt <= 3'h0;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                S_ADDR, S_WDATA: begin
                    // R06 bits sampled MSB first
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_q};
                        cnt <= cnt + 3'h1;
                        if (cnt == 3'h7) begin
                            state <= (state == S_ADDR) ? S_ACHK : S_WCHK;
                        end
                    end
                end
                S_ACHK: begin
                    // R06 acknowledge own address
                    if (scl_fall) begin
                        if (addr_hit) begin
                            sda_oe <= 1'b1;
                            rd_dir <= shreg[0];
                            snap <= light_count_result;
                            state <= S_AACK;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                end
                S_AACK: begin
                    if (scl_fall) begin
                        cnt <= 3'h0;
                        if (rd_dir) begin
                            // R08 first data bit out
                            tx <= first_byte;
                            sda_oe <= ~first_byte[7];
                            state <= S_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state <= S_WDATA;
                        end
                    end
                end
                S_WCHK: begin
                    // R07 acknowledge data byte
                    if (scl_fall) begin
                        sda_oe <= 1'b1;
                        state <= S_WACK;
                    end
                end
                S_WACK: begin
                    // R04 later bytes are not acknowledged
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        state <= S_IDLE;
                    end
                end
                S_RDATA: begin
                    // R08 shift out MSB first
                    if (scl_fall) begin
                        cnt <= cnt + 3'h1;
                        tx <= {tx[6:0], 1'b0};
                        sda_oe <= (cnt == 3'h7) ? 1'b0 : ~tx[6];
                        if (cnt == 3'h7) begin
                            state <= S_RACK;
                        end
                    end
                end
                S_RACK: begin
                    // R09 master NACK ends transmission
                    if (scl_rise) begin
                        state <= sda_q ? S_IDLE : S_RNEXT;
                    end
                end
                S_RNEXT: begin
                    if (scl_fall) begin
                        cnt <= 3'h0;
                        tx <= second_byte;
                        sda_oe <= ~second_byte[7];
                        state <= S_RDATA;
                    end
                end
                default: begin
                    state <= S_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Command byte and integration
    // ****************************************
    // A pulse landing in the cycle of a command is dropped; it is one count at most.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            // R12 power-up in shut-down
            sensor_control_byte <= `ALS_CTRL_RST;
            light_count_result <= `ALS_RESULT_RST;
            active <= 1'b0;
            integrating <= 1'b0;
        end else if (cmd_take) begin
            // R01 R05 R13 R17 R22 store every byte
            sensor_control_byte <= cmd;
            if (cmd_shutdown) begin
                // R12 top bit forces shut-down
                active <= 1'b0;
                integrating <= 1'b0;
            end else if (cmd == `ALS_CMD_ACTIVATE) begin
                // R14 enter one-time integration
                active <= 1'b1;
            end else if (cmd == `ALS_CMD_START && active) begin
                // R15 R19 clear result and start
                light_count_result <= `ALS_RESULT_RST;
                integrating <= 1'b1;
            end else if (cmd == `ALS_CMD_STOP && active && integrating) begin
                // R11 R16 stop and mark valid
                integrating <= 1'b0;
                light_count_result[`ALS_VALID_BIT] <= 1'b1;
            end
        end else if (integrating && freq_rise && !count_full) begin
            // R10 R20 fifteen-bit pulse count
            light_count_result[14:0] <= light_count_result[14:0] + 15'h0001;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = sda_oe;
    assign ctrl_byte_o = sensor_control_byte;
    assign result_o = light_count_result;
    assign active_o = active;
    assign integrating_o = integrating;
endmodule

// >>> verilog/als_host_end.sv
// Controller end: AXI4-Lite registers driving a two-wire master.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "als_regs.svh"
module als_host_end
    import als_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Two-wire link
    als_link_if.host link,
    // AXI4-Lite write
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    localparam logic [15:0] QTR_LAST = 16'(`ALS_QTR_CYCLES - 1);
    als_mst_state_t state;
    logic sda_q;
    logic [3:0] aw_addr;
    logic aw_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_have;
    logic busy;
    logic nack;
    logic rw;
    logic word;
    logic [7:0] txd;
    logic [7:0] sh;
    logic [15:0] rx;
    logic [15:0] qcnt;
    logic [1:0] phase;
    logic [3:0] bit_idx;
    logic [1:0] byte_idx;
    logic ack_in;
    logic scl_oe;
    logic sda_oe;

    als_sync3 #(.RST_VAL(1'b1)) u_sda (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .d_i(link.sda), .q_o(sda_q));

    // ****************************************
    // Register decode
    // ****************************************
    wire aw_hs = s_axi_awvalid_i & s_axi_awready_o;
    wire w_hs = s_axi_wvalid_i & s_axi_wready_o;
    wire ar_hs = s_axi_arvalid_i & s_axi_arready_o;
    wire wr_fire = aw_have & w_have & ~s_axi_bvalid_o;
    wire wr_hit = (aw_addr == `ALS_REG_CMD);
    wire cmd_go = wr_fire & wr_hit & w_strb[0] & ~busy;
    wire [1:0] op = w_data[1:0];
    wire rd_hit = (s_axi_araddr_i == `ALS_REG_CMD) | (s_axi_araddr_i == `ALS_REG_STATUS) |
                  (s_axi_araddr_i == `ALS_REG_RXDATA);
    wire [31:0] status_word = {30'h0, nack, busy};
    wire [31:0] cmd_word = {16'h0, txd, 5'h0, word, rw, 1'b0};
    wire [31:0] rd_word = (s_axi_araddr_i == `ALS_REG_STATUS) ? status_word :
                          (s_axi_araddr_i == `ALS_REG_RXDATA) ? {16'h0, rx} :
                          (s_axi_araddr_i == `ALS_REG_CMD) ? cmd_word : 32'h0;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `ALS_RESP_OKAY;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_addr <= s_axi_awaddr_i;
                aw_have <= 1'b1;
                s_axi_awready_o <= 1'b0;
            end else if (!aw_have) begin
                s_axi_awready_o <= 1'b1;
            end
            if (w_hs) begin
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
                w_have <= 1'b1;
                s_axi_wready_o <= 1'b0;
            end else if (!w_have) begin
                s_axi_wready_o <= 1'b1;
            end
            if (wr_fire) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_hit ? `ALS_RESP_OKAY : `ALS_RESP_SLVERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                aw_have <= 1'b0;
                w_have <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0;
            s_axi_rresp_o <= `ALS_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_word;
            s_axi_rresp_o <= rd_hit ? `ALS_RESP_OKAY : `ALS_RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end else if (!s_axi_rvalid_o) begin
            s_axi_arready_o <= 1'b1;
        end
    end

    // ****************************************
    // Two-wire master engine
    // ****************************************
    wire tick = busy & (qcnt == QTR_LAST);
    wire last_byte = word ? (byte_idx == 2'h2) : (byte_idx == 2'h1);
    wire [7:0] tx_byte = (byte_idx == 2'h0) ? {`ALS_DEV_ADDR, rw} : (rw ? 8'hFF : txd);
    // R09 ACK every read byte but the last
    wire ack_out = (byte_idx == 2'h0) | ~rw | last_byte;
    wire bit_val = (bit_idx == 4'h8) ? ack_out : tx_byte[3'h7 - bit_idx[2:0]];
    wire slave_nack = ack_in & ((byte_idx == 2'h0) | ~rw);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state <= M_IDLE;
            busy <= 1'b0;
            nack <= 1'b0;
            rw <= 1'b0;
            word <= 1'b0;
            txd <= 8'h00;
            sh <= 8'h00;
            rx <= 16'h0000;
            qcnt <= 16'h0000;
            phase <= 2'h0;
            bit_idx <= 4'h0;
            byte_idx <= 2'h0;
            ack_in <= 1'b1;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else if (cmd_go) begin
            // R18 software orders each Send Byte
            state <= M_START;
            busy <= 1'b1;
            nack <= 1'b0;
            rw <= (op != `ALS_OP_SEND);
            word <= (op == `ALS_OP_RECV_WORD);
            txd <= w_strb[1] ? w_data[15:8] : txd;
            qcnt <= 16'h0000;
            phase <= 2'h0;
            bit_idx <= 4'h0;
            byte_idx <= 2'h0;
        end else if (busy) begin
            qcnt <= tick ? 16'h0000 : qcnt + 16'h0001;
            if (tick) begin
                phase <= phase + 2'h1;
                case (state)
                    M_START: begin
                        // R06 start: data falls while clock high
                        if (phase == 2'h1) sda_oe <= 1'b1;
                        if (phase == 2'h2) scl_oe <= 1'b1;
                        if (phase == 2'h3) state <= M_BIT;
                    end
                    M_BIT: begin
                        // R07 bits driven MSB first
                        if (phase == 2'h0) sda_oe <= ~bit_val;
                        if (phase == 2'h1) scl_oe <= 1'b0;
                        if (phase == 2'h2 && bit_idx != 4'h8) sh <= {sh[6:0], sda_q};
                        if (phase == 2'h2 && bit_idx == 4'h8) ack_in <= sda_q;
                        if (phase == 2'h3) begin
                            scl_oe <= 1'b1;
                            bit_idx <= (bit_idx == 4'h8) ? 4'h0 : bit_idx + 4'h1;
                        end
                        if (phase == 2'h3 && bit_idx == 4'h8) begin
                            if (rw && byte_idx == 2'h1) rx[7:0] <= sh;
                            if (rw && byte_idx == 2'h2) rx[15:8] <= sh;
                            if (slave_nack) nack <= 1'b1;
                            if (slave_nack || last_byte) state <= M_STOP;
                            byte_idx <= byte_idx + 2'h1;
                        end
                    end
                    M_STOP: begin
                        // R08 stop after the final bit
                        if (phase == 2'h0) sda_oe <= 1'b1;
                        if (phase == 2'h1) scl_oe <= 1'b0;
                        if (phase == 2'h2) sda_oe <= 1'b0;
                        if (phase == 2'h3) begin
                            state <= M_IDLE;
                            busy <= 1'b0;
                        end
                    end
                    default: begin
                        state <= M_IDLE;
                        busy <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign link.host_scl_o = 1'b0;
    assign link.host_scl_oe = scl_oe;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = sda_oe;
endmodule

// >>> tb/als_link_props.sv
// Checker for the two-wire link that joins the controller and sensor ends.
`timescale 1ns/1ps
module als_link_props (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Link signals
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q, sda_q, rd_f;
    logic [4:0] cnt;
    logic [7:0] sh;
    wire rise = scl & ~scl_q;
    wire strt = scl & scl_q & sda_q & ~sda;
    // Bit slots are counted from each start, so the acknowledge slots are known by number.
    always_ff @(posedge sys_clk_i) begin
        scl_q <= rst_i | scl;
        sda_q <= rst_i | sda;
        if (rst_i | strt) cnt <= 5'h00;
        else if (rise) cnt <= cnt + 5'h01;
        if (rise) sh <= {sh[6:0], sda};
        if (rise && cnt == 5'h08) rd_f <= sh[0];
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence ack_slot;
        rise && cnt == 5'h08;
    endsequence
    addr_ack_a: assert property (ack_slot |-> dev_sda_oe == (sh[7:1] == 7'h29))
        else $error("address acknowledge wrong");
    data_ack_a: assert property (rise && cnt == 5'h11 && !rd_f |-> dev_sda_oe)
        else $error("data byte not acknowledged");
    host_turn_a: assert property (rise && cnt == 5'h11 && rd_f |-> !dev_sda_oe)
        else $error("sensor holds data in master reply slot");
    word_end_a: assert property (rise && cnt == 5'h1A && rd_f |-> !dev_sda_oe)
        else $error("sensor holds data after second byte");
    hold_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("sensor data moved while clock high");
    turn_low_a: assert property ($changed(dev_sda_oe) |-> !scl && $past(scl, 3) == 1'b0)
        else $error("sensor data moved outside clock low");
    no_start_a: assert property (strt |-> !dev_sda_oe)
        else $error("sensor took part in a start");
    scl_high_a: assert property (rise |-> scl [*8])
        else $error("clock high period too short");
endmodule

// >>> tb/tb.sv
// Testbench joining the controller and sensor ends over the two-wire link.
`timescale 1ns/1ps
module tb;
    logic c = 1'b0, r = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic fq = 1'b0, awr, wrd, bv, arr, rv, act, intg;
    logic [3:0] awa = 4'h0, ara = 4'h0;
    logic [31:0] wd = 32'h0, st, rdt;
    logic [1:0] br, rr;
    logic [7:0] ctl;
    logic [15:0] res;
    logic [33:0] eq[$], mq[$];
    logic [1:0] bq[$];
    int bad_count = 0, check_count = 0, np;
    integer seed = 32'hcab7b10c;
    always #5 c = ~c;
    als_link_if lnk ();
    als_host_end i_als_host_end (.sys_clk_i(c), .rst_i(r), .link(lnk.host),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
        .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre));
    als_dev_end i_als_dev_end (.sys_clk_i(c), .rst_i(r), .link(lnk.dev), .freq_i(fq),
        .ctrl_byte_o(ctl), .result_o(res), .active_o(act), .integrating_o(intg));
    als_link_props u_props (.sys_clk_i(c), .rst_i(r), .host_scl_o(lnk.host_scl_o),
        .host_scl_oe(lnk.host_scl_oe), .host_sda_o(lnk.host_sda_o),
        .host_sda_oe(lnk.host_sda_oe), .dev_sda_o(lnk.dev_sda_o),
        .dev_sda_oe(lnk.dev_sda_oe), .scl(lnk.scl), .sda(lnk.sda));
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tmo(input bit t);
        if (t) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        n = 0;
        @(posedge c);
        bq.push_back(e);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge c);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            n++;
        end while (!bv && n < 4000);
        bre <= 1'b0;
        tmo(n >= 4000);
    endtask
    task automatic rd(input logic [3:0] a, input logic [33:0] e, input logic [33:0] m);
        int n;
        n = 0;
        @(posedge c);
        eq.push_back(e);
        mq.push_back(m);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge c);
            if (arr) arv <= 1'b0;
            n++;
        end while (!rv && n < 4000);
        st = rdt;
        rre <= 1'b0;
        tmo(n >= 4000);
    endtask
    // The second command lands while busy; it must be dropped, or the state would differ.
    task automatic frame(input logic [1:0] op, input logic [7:0] b);
        int n;
        wr(4'h0, {16'h0, b, 6'h0, op}, 2'h0);
        wr(4'h0, 32'h0000_FF00, 2'h0);
        n = 0;
        do begin
            rd(4'h4, 34'h0, 34'h3_0000_0002);
            n++;
        end while (st[0] && n < 20000);
        tmo(n >= 20000);
    endtask
    task automatic pulse(input int k);
        repeat (k) begin
            repeat (6) @(posedge c);
            fq <= 1'b1;
            repeat (6) @(posedge c);
            fq <= 1'b0;
        end
    endtask
    always @(posedge c) begin
        if (bv && bre) chk("bresp", 34'(bq.pop_front()), 34'(br));
        if (rv && rre) chk("rdata", eq.pop_front(), {rr, rdt} & mq.pop_front());
    end
    initial begin
        repeat (3) @(posedge c);
        r <= 1'b0;
        repeat (2) @(posedge c);
        chk("ctrl", 34'h80, 34'(ctl));
        chk("active", 34'h0, 34'(act));
        frame(2'h1, 8'h00);
        rd(4'h8, 34'h80, 34'h3_0000_00FF);
        $display("test byte read done");
        frame(2'h0, 8'h04);
        chk("ctrl", 34'h04, 34'(ctl));
        chk("active", 34'h1, 34'(act));
        frame(2'h0, 8'h08);
        chk("integrating", 34'h1, 34'(intg));
        np = ($random(seed) & 63) + 3;
        pulse(np);
        repeat (10) @(posedge c);
        chk("count", 34'(np), 34'(res));
        frame(2'h0, 8'h30);
        chk("result", 34'(np) | 34'h8000, 34'(res));
        chk("integrating", 34'h0, 34'(intg));
        pulse(4);
        chk("held", 34'(np) | 34'h8000, 34'(res));
        $display("test integration done");
        frame(2'h2, 8'h00);
        rd(4'h8, 34'(np) | 34'h8000, 34'h3_0000_FFFF);
        frame(2'h0, 8'hB4);
        chk("active", 34'h0, 34'(act));
        frame(2'h1, 8'h00);
        rd(4'h8, 34'hB4, 34'h3_0000_00FF);
        rd(4'hC, 34'h2_0000_0000, 34'h3_FFFF_FFFF);
        $display("test word read done");
        tally_and_finish();
    end
endmodule
